// [common/pin_test_pkg.sv]
// Constants and carrier types for the pin-level manufacturing test logic
`default_nettype none
package pin_test_pkg;

	localparam int PCI_PIN_W  = 88;
	localparam int PHY_PIN_W  = 26;
	localparam int SIDE_PIN_W = 58;
	localparam int TREE_W     = PCI_PIN_W + PHY_PIN_W + SIDE_PIN_W;
	localparam int SEL_W      = 4;
	localparam int REG_CTRL_W = 3;
	localparam int SYNC_W     = 2 + SEL_W + TREE_W;

	localparam logic [SEL_W-1:0] XOR_SEL_CODE = 4'h0;
	localparam logic [SEL_W-1:0] TRI_SEL_CODE = 4'h5;

	localparam logic CE_N_RESET = 1'h1;

	typedef enum logic [1:0] {
		MODE_NORMAL,
		MODE_XOR,
		MODE_TRISTATE
	} test_mode_t;

	// Tested pins, grouped by interface
	typedef struct packed {
		logic [PCI_PIN_W-1:0]  pci;
		logic [PHY_PIN_W-1:0]  phy;
		logic [SIDE_PIN_W-1:0] side;
	} tree_pins_t;

	// One output pin: value and driver enable
	typedef struct packed {
		logic value;
		logic oe;
	} pin_drive_t;

endpackage
`default_nettype wire

// [dv/pin_fixture.sv]
// Board fixture model driving the tested pins
`timescale 1ns/1ps
`default_nettype none
module pin_fixture
	import pin_test_pkg::*;
(
	input  wire logic       core_clk_in,
	input  wire logic       set_in,
	input  wire logic [7:0] idx_in,
	input  wire logic       level_in,
	output var  tree_pins_t pins_out
);
	initial pins_out = '0;
	always @(posedge core_clk_in) begin
		if (set_in) begin
			pins_out[idx_in] <= level_in;
		end
	end
endmodule
`default_nettype wire

// [dv/test_pin_test_ctrl.sv]
// Self-checking bench for the pin test controller
`timescale 1ns/1ps
`default_nettype none
module test_pin_test_ctrl;
	import pin_test_pkg::*;
	logic                  clk, rstn, en_n, hz, set, lvl;
	logic [3:0]            sel;
	logic [7:0]            idx;
	logic [REG_CTRL_W-1:0] rc, rc_out;
	tree_pins_t            pins, fo, foe, t_out, t_oe, exp_pins;
	pin_drive_t            fce, ftdo, fal, ce, tdo, al;
	test_mode_t            mode;
	int                    n_fail, n_compared, cyc;
	int                    sel_idx [6] = '{0, 87, 88, 113, 114, 171};

	pin_test_ctrl dut (.core_clk_in(clk), .rstn_in(rstn),
		.test_decode_enable_n_in(en_n), .mode_select_bit3_pin_in(sel[3]),
		.mode_select_bit2_pin_in(sel[2]), .mode_select_bit1_pin_in(sel[1]),
		.mode_select_bit0_pin_in(sel[0]), .highz_instr_in(hz),
		.tree_pin_in(pins), .func_tree_out_in(fo), .func_tree_oe_in(foe),
		.func_flash_ce_n_in(fce), .func_tdo_in(ftdo), .func_alert_in(fal),
		.func_reg_ctrl_in(rc), .tree_pin_out(t_out), .tree_pin_oe_out(t_oe),
		.flash_chip_enable_n_out(ce), .tdo_out(tdo), .alert_out(al),
		.reg_ctrl_out(rc_out), .test_mode_out(mode));
	pin_fixture fix (.core_clk_in(clk), .set_in(set), .idx_in(idx),
		.level_in(lvl), .pins_out(pins));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic check(input logic [TREE_W-1:0] seen, exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic summarize;
		$display("Compared %0d, mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// Sync, mode and output registers need four edges
	task automatic strap(input logic e, input logic [3:0] s, input logic h);
		@(negedge clk);
		en_n = e;
		sel = s;
		hz = h;
		repeat (6) @(negedge clk);
	endtask

	task automatic drive_pin(input int i, input logic v);
		@(negedge clk);
		idx = 8'(i);
		lvl = v;
		set = 1'b1;
		@(negedge clk);
		set = 1'b0;
		exp_pins[i] = v;
		repeat (5) @(negedge clk);
	endtask

	task automatic t_normal(input logic e, input logic [3:0] s);
		strap(e, s, 1'b0);
		check(mode, MODE_NORMAL);
		check(t_oe, foe);
		check(t_out, fo);
		check({ce, tdo, al}, {fce, ftdo, fal});
	endtask

	task automatic t_xor;
		strap(1'b0, 4'h0, 1'b0);
		check(mode, MODE_XOR);
		check(t_oe, '0);
		check(ce.oe, 1'b1);
		check(rc_out, rc);
		for (int k = 0; k < 6; k++) begin
			drive_pin(sel_idx[k], 1'b1);
			check(ce.value, ^exp_pins);
			drive_pin(sel_idx[k], 1'b0);
			check(ce.value, ^exp_pins);
		end
	endtask

	task automatic t_tri(input logic [3:0] s, input logic h);
		strap(1'b0, s, h);
		check(mode, MODE_TRISTATE);
		check(t_oe, '0);
		check({ce.oe, al.oe}, 2'h0);
		check(tdo, ftdo);
		check(rc_out, rc);
	endtask

	always @(posedge clk) begin
		cyc++;
		// Ceiling well above the run length
		if (cyc > 2000) begin
			n_fail++;
			summarize();
		end
	end

	initial begin
		{rstn, en_n, hz, set, lvl, idx, sel} = '0;
		en_n = 1'b1;
		exp_pins = '0;
		for (int k = 0; k < TREE_W; k++) begin
			fo[k] = k[0];
			foe[k] = ~k[1];
		end
		fce = 2'h1;
		ftdo = 2'h1;
		fal = 2'h3;
		rc = 3'h5;
		repeat (8) @(negedge clk);
		check({t_oe, ce, mode}, {{TREE_W{1'b0}}, 2'h2, MODE_NORMAL});
		rstn = 1'b1;
		t_normal(1'b1, 4'h0);
		t_xor();
		t_tri(4'h5, 1'b0);
		t_tri(4'h0, 1'b1);
		t_normal(1'b0, 4'h1);
		t_normal(1'b1, 4'h5);
		summarize();
	end
endmodule
`default_nettype wire

// [hw/pin_sync.sv]
// Two-stage synchroniser for pin-level inputs
`timescale 1ns/1ps
`default_nettype none
module pin_sync
	import pin_test_pkg::*;
#(
	parameter int WIDTH = 1
) (
	input  wire logic             core_clk_in,
	input  wire logic             rstn_in,
	input  wire logic [WIDTH-1:0] async_in,
	output var  logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta;
	logic [WIDTH-1:0] next_meta;
	logic [WIDTH-1:0] next_sync;

	// First stage read only by second stage
	always_comb begin
		next_meta = rstn_in ? async_in : '0;
		next_sync = rstn_in ? meta : '0;
	end

	always_ff @(posedge core_clk_in) begin
		meta     <= next_meta;
		sync_out <= next_sync;
	end

endmodule
`default_nettype wire

// [hw/pin_test_ctrl.sv]
// Test mode decode, XOR tree and driver release for the device pins
`timescale 1ns/1ps
`default_nettype none
// Function
// - Decode enable low and select 0000 enters XOR-tree mode.
// - XOR-tree mode releases drivers of every tested pin.
// - XOR-tree mode drives the final tree result on flash chip-enable.
// - Tree is a cascade of two-input XOR stages, one pin each.
// - Tested pins act as inputs in XOR-tree mode.
// - Tree covers PCI, PHY/SERDES, EEPROM, flash, LED, SMBus, SDP, alt clock.
// - JTAG, decode, analog, compensation, oscillator, power, alert pins excluded.
// - Decode enable low and select 0101 enters tristate mode.
// - Tristate mode releases all digital drivers except test data out.
// - Tristate mode leaves analog and regulator control outputs alone.
// - HIGHZ instruction releases every digital signal output except test data out.
module pin_test_ctrl
	import pin_test_pkg::*;
(
	input  wire logic                  core_clk_in,
	input  wire logic                  rstn_in,
	input  wire logic                  test_decode_enable_n_in,
	input  wire logic                  mode_select_bit3_pin_in,
	input  wire logic                  mode_select_bit2_pin_in,
	input  wire logic                  mode_select_bit1_pin_in,
	input  wire logic                  mode_select_bit0_pin_in,
	input  wire logic                  highz_instr_in,
	input  wire tree_pins_t            tree_pin_in,
	input  wire tree_pins_t            func_tree_out_in,
	input  wire tree_pins_t            func_tree_oe_in,
	input  wire pin_drive_t            func_flash_ce_n_in,
	input  wire pin_drive_t            func_tdo_in,
	input  wire pin_drive_t            func_alert_in,
	input  wire logic [REG_CTRL_W-1:0] func_reg_ctrl_in,
	output var  tree_pins_t            tree_pin_out,
	output var  tree_pins_t            tree_pin_oe_out,
	output var  pin_drive_t            flash_chip_enable_n_out,
	output var  pin_drive_t            tdo_out,
	output var  pin_drive_t            alert_out,
	output var  logic [REG_CTRL_W-1:0] reg_ctrl_out,
	output var  test_mode_t            test_mode_out
);

	logic [SYNC_W-1:0]   raw_pins;
	logic [SYNC_W-1:0]   sync_pins;
	logic                decode_en;
	logic                highz;
	logic [SEL_W-1:0]    sel;
	logic [TREE_W-1:0]   tree_vec;
	logic [TREE_W:0]     stage;
	logic                tree_result;

	test_mode_t          mode;
	test_mode_t          next_mode;
	tree_pins_t          next_tree_out;
	tree_pins_t          next_tree_oe;
	pin_drive_t          next_flash;
	pin_drive_t          next_tdo;
	pin_drive_t          next_alert;
	logic [REG_CTRL_W-1:0] next_reg_ctrl;

	// Enable inverted ahead of the flops so reset reads as disabled
	assign raw_pins = {~test_decode_enable_n_in, highz_instr_in,
		mode_select_bit3_pin_in, mode_select_bit2_pin_in,
		mode_select_bit1_pin_in, mode_select_bit0_pin_in, tree_pin_in};

	pin_sync #(
		.WIDTH (SYNC_W)
	) u_sync (
		.core_clk_in (core_clk_in),
		.rstn_in     (rstn_in),
		.async_in    (raw_pins),
		.sync_out    (sync_pins)
	);

	assign decode_en = sync_pins[SYNC_W-1];
	assign highz     = sync_pins[SYNC_W-2];
	assign sel       = sync_pins[TREE_W+SEL_W-1:TREE_W];
	// only tested pins feed the tree
	assign tree_vec  = sync_pins[TREE_W-1:0];

	// cascade, one unique pin per stage
	assign stage[0] = 1'h0;
	for (genvar i = 0; i < TREE_W; i++) begin : g_tree
		assign stage[i+1] = stage[i] ^ tree_vec[i];
	end
	assign tree_result = stage[TREE_W];

	// Mode decode; HIGHZ overrides the strap decode
	always_comb begin
		next_mode = MODE_NORMAL;
		if (highz) begin
			next_mode = MODE_TRISTATE;
		end else if (decode_en && sel == XOR_SEL_CODE) begin
			next_mode = MODE_XOR;
		end else if (decode_en && sel == TRI_SEL_CODE) begin
			next_mode = MODE_TRISTATE;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (!rstn_in) begin
			mode <= MODE_NORMAL;
		end else begin
			mode <= next_mode;
		end
	end

	// Pin drive selection
	always_comb begin
		next_tree_out = func_tree_out_in;
		next_tree_oe  = func_tree_oe_in;
		next_flash    = func_flash_ce_n_in;
		// Test data out is never released, so a scan chain survives HIGHZ
		next_tdo      = func_tdo_in;
		next_alert    = func_alert_in;
		// regulator controls untouched in every mode
		next_reg_ctrl = func_reg_ctrl_in;
		unique case (mode)
			MODE_NORMAL: begin
				next_tree_oe = func_tree_oe_in;
			end
			MODE_XOR: begin
				// tested pins released, read as inputs
				next_tree_oe     = '0;
				next_flash.value = tree_result;
				next_flash.oe    = 1'h1;
			end
			MODE_TRISTATE: begin
				// every digital driver off except test data out
				next_tree_oe  = '0;
				next_flash.oe = 1'h0;
				next_alert.oe = 1'h0;
			end
		endcase
	end

	always_ff @(posedge core_clk_in) begin
		if (!rstn_in) begin
			tree_pin_out            <= '0;
			tree_pin_oe_out         <= '0;
			flash_chip_enable_n_out <= '{value: CE_N_RESET, oe: 1'h0};
			tdo_out                 <= '0;
			alert_out               <= '0;
			reg_ctrl_out            <= '0;
			test_mode_out           <= MODE_NORMAL;
		end else begin
			tree_pin_out            <= next_tree_out;
			tree_pin_oe_out         <= next_tree_oe;
			flash_chip_enable_n_out <= next_flash;
			tdo_out                 <= next_tdo;
			alert_out               <= next_alert;
			reg_ctrl_out            <= next_reg_ctrl;
			test_mode_out           <= mode;
		end
	end

	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (!rstn_in);

	xor_entry_a: assert property (
		!highz && decode_en && sel == XOR_SEL_CODE |=> mode == MODE_XOR
	) else $error("XOR strap did not select XOR mode");

	xor_release_a: assert property (
		mode == MODE_XOR |=> tree_pin_oe_out == '0
	) else $error("Tested pin driven in XOR mode");

	xor_output_a: assert property (
		mode == MODE_XOR |=> flash_chip_enable_n_out.oe
			&& flash_chip_enable_n_out.value == ^$past(tree_vec)
	) else $error("Tree result not on chip-enable pin");

	tree_cascade_a: assert property (
		tree_result == ^tree_vec
	) else $error("Cascade disagrees with parity of pins");

	pin_follow_a: assert property (
		mode == MODE_XOR ##1 mode == MODE_XOR && $changed(tree_vec)
		|=> $changed(flash_chip_enable_n_out.value)
			== ^($past(tree_vec) ^ $past(tree_vec, 2))
	) else $error("Tree output ignores a pin change");

	tri_entry_a: assert property (
		decode_en && sel == TRI_SEL_CODE |=> mode == MODE_TRISTATE
	) else $error("Tristate strap did not select tristate mode");

	tri_release_a: assert property (
		mode == MODE_TRISTATE |=> tree_pin_oe_out == '0
			&& !flash_chip_enable_n_out.oe && !alert_out.oe
			&& tdo_out == $past(func_tdo_in)
	) else $error("Digital driver left on in tristate");

	analog_keep_a: assert property (
		$past(rstn_in) |-> reg_ctrl_out == $past(func_reg_ctrl_in)
	) else $error("Regulator control disturbed");

	highz_entry_a: assert property (
		highz |=> mode == MODE_TRISTATE ##1 tree_pin_oe_out == '0
	) else $error("HIGHZ did not release outputs");

	normal_keep_a: assert property (
		!highz
		&& !(decode_en && (sel == XOR_SEL_CODE || sel == TRI_SEL_CODE))
		|=> ##1 tree_pin_oe_out == $past(func_tree_oe_in)
			&& flash_chip_enable_n_out == $past(func_flash_ce_n_in)
	) else $error("Normal drive not kept");

	xor_seen_c: cover property (mode == MODE_XOR ##1 $changed(tree_result));
	tri_seen_c: cover property (!highz ##1 mode == MODE_TRISTATE);
	highz_seen_c: cover property (highz ##2 tree_pin_oe_out == '0);

endmodule
`default_nettype wire
